// File: scp_pkg.sv
// Summary of operation
// - while chip select is low, each rising serial clock edge shifts the data line into the frame.
// - when chip select rises, a complete write frame is committed to the register it addresses.
// - the read/write flag selects the direction, 0 for a register write and 1 for a register read.
// - during a read, data is updated after each falling serial clock edge, valid within 120 ns.
// - in 4-wire mode the readback pin carries read data with the same timing as the data line.
package scp_pkg;
  localparam int          ADDR_W     = 7;      // register address bits in the header
  localparam int          DATA_W     = 8;      // data byte width
  localparam int          HDR_BITS   = 1 + ADDR_W;
  localparam int          FRAME_BITS = HDR_BITS + DATA_W;
  localparam int          CNT_W      = 5;      // frame bit counter width
  localparam logic [0:0]  RW_WRITE   = 1'h0;   // flag value requesting a write
  localparam logic [0:0]  RW_READ    = 1'h1;   // flag value requesting a read
  localparam logic [7:0]  REG_RST    = 8'h00;  // reset value of every configuration register
  localparam int          CLK_NS     = 10;     // mclk period
  localparam int          T_DV_NS    = 120;    // longest fall-to-valid time of read data
  localparam int          DV_CYC     = T_DV_NS / CLK_NS; // longest time, rounded down

  // one-hot frame states
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_HDR   = 4'h2,
    ST_WDATA = 4'h4,
    ST_RDATA = 4'h8
  } scp_state_t;
endpackage : scp_pkg

// File: scp_sync2.sv
// two-flop synchroniser for pin levels; only the second stage is visible
module scp_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk_i,   // system clock
  input  wire logic             rst_n_i,  // synchronous reset, active low
  input  wire logic [WIDTH-1:0] async_i,  // levels from outside the clock domain
  input  wire logic [WIDTH-1:0] rst_val_i, // idle level loaded during reset
  output logic      [WIDTH-1:0] sync_o    // synchronised levels
);
  logic [WIDTH-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge mclk_i) begin
    // both stages load the idle level so no false edge follows reset
    if (!rst_n_i) begin
      meta_r <= rst_val_i;
      sync_o <= rst_val_i;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end
endmodule : scp_sync2

// File: scp_serial_port.sv
// serial configuration port: 3-wire or 4-wire, frames of flag, address and data
module scp_serial_port
  import scp_pkg::*;
(
  input  wire logic              mclk_i,      // system clock, 100 MHz
  input  wire logic              rst_n_i,     // synchronous reset, active low
  input  wire logic              cs_n_i,      // chip select pin, active low
  input  wire logic              sck_i,       // serial clock pin
  input  wire logic              sdio_i,      // serial_data_in, bidirectional line input
  output logic                   sdio_o,      // bidirectional line output value
  output logic                   sdio_oe_o,   // high while driving the data line
  output logic                   readback_o,  // 4-wire readback pin
  output logic                   readback_oe_o, // high while driving the readback pin
  input  wire logic              four_wire_i, // 1 selects 4-wire readback
  output logic                   wr_stb_o,    // one-cycle pulse on register commit
  output logic      [ADDR_W-1:0] wr_addr_o,   // address of the committed register
  output logic      [DATA_W-1:0] wr_data_o    // value committed
);
  localparam int DV_LIM = DV_CYC;

  logic [3:0]              pin_s;
  logic                    cs_s;
  logic                    sck_s;
  logic                    sdi_s;
  logic                    sck_d_r;
  logic                    cs_d_r;
  logic                    sck_rise;
  logic                    sck_fall;
  logic                    cs_rise;
  logic                    cs_fall;
  scp_state_t              state_r;
  logic [CNT_W-1:0]        cnt_r;
  logic [FRAME_BITS-1:0]   shift_r;
  logic [HDR_BITS-1:0]     hdr_nxt;
  logic                    rw_r;
  logic [ADDR_W-1:0]       addr_r;
  logic [DATA_W-1:0]       rd_shift_r;
  logic                    data_out_r;
  logic                    data_upd_r;
  logic                    four_wire_r;
  logic [DATA_W-1:0]       regs_r [2**ADDR_W];

  // pins cross into the mclk domain; chip select idles high, so reset loads it high
  scp_sync2 #(.WIDTH(4)) i_scp_sync2 (
    .mclk_i    (mclk_i),
    .rst_n_i   (rst_n_i),
    .async_i   ({four_wire_i, cs_n_i, sck_i, sdio_i}),
    .rst_val_i (4'h4),
    .sync_o    (pin_s)
  );

  assign cs_s  = pin_s[2];
  assign sck_s = pin_s[1];
  assign sdi_s = pin_s[0];

  // edge finding on the synchronised levels
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      sck_d_r <= 1'h0;
      cs_d_r  <= 1'h1;
    end else begin
      sck_d_r <= sck_s;
      cs_d_r  <= cs_s;
    end
  end

  assign sck_rise = sck_s & ~sck_d_r;
  assign sck_fall = ~sck_s & sck_d_r;
  assign cs_rise  = cs_s & ~cs_d_r;
  assign cs_fall  = ~cs_s & cs_d_r;
  assign hdr_nxt  = {shift_r[HDR_BITS-2:0], sdi_s};

  // mode pin is static; it is synchronised like the other pins, then held here
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      four_wire_r <= 1'h0;
    end else begin
      four_wire_r <= pin_s[3];
    end
  end

  // frame sequencing: header first, then data in the direction the flag asks
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state_r <= ST_IDLE;
      cnt_r   <= '0;
      rw_r    <= RW_WRITE;
      addr_r  <= '0;
    end else if (cs_rise || cs_s) begin
      state_r <= ST_IDLE;
    end else if (cs_fall) begin
      state_r <= ST_HDR;
      cnt_r   <= '0;
    end else if (sck_rise && state_r != ST_IDLE) begin
      if (cnt_r != '1) begin
        cnt_r <= cnt_r + 1'b1;
      end
      if (state_r == ST_HDR && cnt_r == CNT_W'(HDR_BITS - 1)) begin
        rw_r   <= hdr_nxt[HDR_BITS-1];
        addr_r <= hdr_nxt[ADDR_W-1:0];
        if (hdr_nxt[HDR_BITS-1] == RW_READ) begin
          state_r <= ST_RDATA;
        end else begin
          state_r <= ST_WDATA;
        end
      end
    end
  end

  // msb-first shift on each rising serial clock edge inside the frame
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      shift_r <= '0;
    end else if (sck_rise && !cs_s) begin
      shift_r <= {shift_r[FRAME_BITS-2:0], sdi_s};
    end
  end

  // commit on chip select rising; short or overlong frames are dropped
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      wr_stb_o  <= 1'h0;
      wr_addr_o <= '0;
      wr_data_o <= '0;
      for (int i = 0; i < 2**ADDR_W; i++) begin
        regs_r[i] <= REG_RST;
      end
    end else begin
      wr_stb_o <= 1'h0;
      if (cs_rise && state_r == ST_WDATA && cnt_r == CNT_W'(FRAME_BITS)) begin
        regs_r[addr_r] <= shift_r[DATA_W-1:0];
        wr_stb_o       <= 1'h1;
        wr_addr_o      <= addr_r;
        wr_data_o      <= shift_r[DATA_W-1:0];
      end
    end
  end

  // read data launches after falling edges; loaded when the header completes
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rd_shift_r <= '0;
      data_out_r <= 1'h0;
      data_upd_r <= 1'h0;
    end else begin
      data_upd_r <= 1'h0;
      if (sck_rise && state_r == ST_HDR && cnt_r == CNT_W'(HDR_BITS - 1)) begin
        rd_shift_r <= regs_r[hdr_nxt[ADDR_W-1:0]];
      end else if (sck_fall && state_r == ST_RDATA && !cs_s) begin
        data_out_r <= rd_shift_r[DATA_W-1];
        rd_shift_r <= {rd_shift_r[DATA_W-2:0], 1'h0};
        data_upd_r <= 1'h1;
      end
    end
  end

  // one launch path feeds both pins so their timing cannot differ
  assign sdio_o        = data_out_r;
  assign readback_o    = data_out_r;
  assign sdio_oe_o     = (state_r == ST_RDATA) && !four_wire_r && (cnt_r > CNT_W'(HDR_BITS - 1));
  assign readback_oe_o = (state_r == ST_RDATA) && four_wire_r;

  // checks: the synchroniser adds two cycles, well inside the valid window
  property p_shift_count;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (sck_rise && !cs_s && state_r == ST_HDR) |=> (cnt_r == $past(cnt_r) + 1'b1);
  endproperty
  a_shift_count: assert property (p_shift_count)
    else $error("bit counter did not advance on serial clock rise");

  property p_shift_in;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (sck_rise && !cs_s) |=> (shift_r[0] == $past(sdi_s));
  endproperty
  a_shift_in: assert property (p_shift_in)
    else $error("data line level not captured");

  property p_commit;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (cs_rise && state_r == ST_WDATA && cnt_r == CNT_W'(FRAME_BITS))
        |=> wr_stb_o && (wr_data_o == $past(shift_r[DATA_W-1:0])) && (wr_addr_o == $past(addr_r));
  endproperty
  a_commit: assert property (p_commit)
    else $error("write frame not committed on chip select rise");

  property p_no_read_commit;
    @(posedge mclk_i) disable iff (!rst_n_i)
      wr_stb_o |-> $past(rw_r) == RW_WRITE;
  endproperty
  a_no_read_commit: assert property (p_no_read_commit)
    else $error("commit seen on a read frame");

  property p_read_state;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (state_r == ST_RDATA) |-> (rw_r == RW_READ);
  endproperty
  a_read_state: assert property (p_read_state)
    else $error("read phase entered without read flag");

  property p_dv;
    @(posedge mclk_i) disable iff (!rst_n_i)
      ($fell(sck_i) && !cs_n_i && state_r == ST_RDATA && !cs_s) |-> ##[1:DV_LIM] data_upd_r;
  endproperty
  a_dv: assert property (p_dv)
    else $error("read data not updated within valid window");

  property p_four_wire;
    @(posedge mclk_i) disable iff (!rst_n_i)
      four_wire_r |-> !sdio_oe_o && (readback_o == sdio_o);
  endproperty
  a_four_wire: assert property (p_four_wire)
    else $error("4-wire readback differs from data line timing");

  property p_frame_start;
    @(posedge mclk_i) disable iff (!rst_n_i)
      cs_fall |=> (state_r == ST_HDR) && (cnt_r == '0);
  endproperty
  a_frame_start: assert property (p_frame_start)
    else $error("frame did not start with header on chip select fall");

  // readback pin may only move at a launch, never between falling edges
  property p_rb_launch;
    @(posedge mclk_i) disable iff (!rst_n_i)
      $changed(readback_o) |-> data_upd_r;
  endproperty
  a_rb_launch: assert property (p_rb_launch)
    else $error("readback pin changed outside a launch");

  property p_short_drop;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (cs_rise && cnt_r != CNT_W'(FRAME_BITS)) |=> !wr_stb_o;
  endproperty
  a_short_drop: assert property (p_short_drop)
    else $error("frame of wrong length committed");

  property p_idle_release;
    @(posedge mclk_i) disable iff (!rst_n_i)
      cs_rise |=> (state_r == ST_IDLE) && !sdio_oe_o && !readback_oe_o;
  endproperty
  a_idle_release: assert property (p_idle_release)
    else $error("port not idle after chip select rise");
endmodule : scp_serial_port

// File: scp_host_model.sv
// behavioural host that frames transfers on the serial port
module scp_host_model
  import scp_pkg::*;
(
  input  wire logic mclk_i,   // system clock, paces the serial clock
  input  wire logic line_i,   // read data level as the host sees it
  output logic      cs_n_o,   // chip select, active low
  output logic      sck_o,    // serial clock, still outside frames
  output logic      sdo_o,    // data the host puts on the line
  output logic      sdo_oe_o  // high while the host drives the line
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle pins at time zero
  initial begin
    cs_n_o   = 1'b1;
    sck_o    = 1'b0;
    sdo_o    = 1'b0;
    sdo_oe_o = 1'b0;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : wait_cyc

  // one frame of nbits, msb first; sck period 16 mclk, data set at each fall
  task automatic xfer(input logic [15:0] word, input int nbits, output logic [7:0] rd);
    int   i;
    logic rd_frame;
    rd       = 8'h00;
    rd_frame = (word[15] == RW_READ); // flag picks direction
    @(posedge mclk_i);
    cs_n_o <= 1'b0; // one low period frames the transfer
    for (i = 0; i < nbits; i++) begin
      if (rd_frame && i >= 8) begin
        sdo_oe_o <= 1'b0; // released: toggle so a stale level never looks valid
        sdo_o    <= ~sdo_o;
      end else begin
        sdo_oe_o <= 1'b1;
        sdo_o    <= (i < 16) ? word[15-i] : 1'b0; // flag, address, data msb first
      end
      wait_cyc(8);
      sck_o <= 1'b1;
      if (rd_frame && i >= 8) rd = {rd[6:0], line_i}; // sampled on rise, 80 ns after fall
      wait_cyc(2); // hold time after the rise
      if (rd_frame && i == 7) begin
        sdo_oe_o <= 1'b0; // turn the line around before the device starts to drive it
        sdo_o    <= ~sdo_o;
      end
      wait_cyc(6);
      sck_o <= 1'b0;
    end
    wait_cyc(8);
    cs_n_o   <= 1'b1; // return high to commit and idle the port
    sdo_oe_o <= 1'b0;
    sdo_o    <= ~sdo_o;
    wait_cyc(8); // cs high gap also covers the commit latency
  endtask : xfer
endmodule : scp_host_model

// File: scp_serial_port_tb.sv
module scp_serial_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import scp_pkg::*;

  logic              mclk_i      = 1'b0;
  logic              rst_n_i     = 1'b0;
  logic              four_wire_i = 1'b0;
  logic              cs_n, sck, h_d, h_oe, sdio_o, sdio_oe_o, rb_o, rb_oe, wr_stb_o;
  logic [ADDR_W-1:0] wr_addr_o, last_addr;
  logic [DATA_W-1:0] wr_data_o, last_data;
  int                err_total   = 0;
  int                checks_done = 0;
  int                commits     = 0;
  int                oe_bad      = 0;
  int                cyc         = 0;
  // no pull on the line: a released host shows a toggling level
  wire logic         line_w  = (sdio_oe_o === 1'b1) ? sdio_o : h_d;
  wire logic         host_in = four_wire_i ? ((rb_oe === 1'b1) ? rb_o : ~rb_o) : line_w;

  always #5 mclk_i = ~mclk_i;

  scp_serial_port i_scp_serial_port (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n),
    .sck_i(sck), .sdio_i(line_w), .sdio_o(sdio_o), .sdio_oe_o(sdio_oe_o), .readback_o(rb_o),
    .readback_oe_o(rb_oe), .four_wire_i(four_wire_i), .wr_stb_o(wr_stb_o),
    .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o));
  scp_host_model i_scp_host_model (.mclk_i(mclk_i), .line_i(host_in), .cs_n_o(cs_n),
    .sck_o(sck), .sdo_o(h_d), .sdo_oe_o(h_oe));

  // commit capture, line contention and the run ceiling
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (wr_stb_o === 1'b1) begin
      commits   <= commits + 1;
      last_addr <= wr_addr_o;
      last_data <= wr_data_o;
    end
    if (sdio_oe_o === 1'b1 && (four_wire_i || h_oe)) oe_bad <= oe_bad + 1;
    if (cyc == 20000) begin
      $display("mismatch at %0t: run ceiling reached", $time);
      err_total++;
      conclude();
    end
  end

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    int         n0;
    logic [7:0] rd;
    n0 = commits;
    i_scp_host_model.xfer({RW_WRITE, a, d}, 16, rd);
    cmp(16'(commits - n0), 16'h0001);
    cmp({9'h000, last_addr}, {9'h000, a});
    cmp({8'h00, last_data}, {8'h00, d});
  endtask : wr

  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
    int         n0;
    logic [7:0] rd;
    n0 = commits;
    i_scp_host_model.xfer({RW_READ, a, 8'h00}, 16, rd);
    cmp({8'h00, rd}, {8'h00, exp});
    cmp(16'(commits - n0), 16'h0000);
  endtask : rd_chk

  // back-to-back writes, alternating and edge patterns
  task automatic t_write;
    wr(7'h7f, 8'ha5);
    wr(7'h00, 8'h5a);
    wr(7'h2a, 8'h81);
  endtask : t_write

  // 3-wire readback, plus a never-written register
  task automatic t_read3;
    rd_chk(7'h7f, 8'ha5);
    rd_chk(7'h13, REG_RST);
    cmp(16'(oe_bad), 16'h0000);
  endtask : t_read3

  // 4-wire readback: data on its own pin, line left alone
  task automatic t_read4;
    @(posedge mclk_i);
    four_wire_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    rd_chk(7'h00, 8'h5a);
    rd_chk(7'h2a, 8'h81);
    cmp(16'(oe_bad), 16'h0000);
    @(posedge mclk_i);
    four_wire_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
  endtask : t_read4

  // short and long frames must not commit
  task automatic t_refuse;
    int         n0;
    logic [7:0] rd;
    n0 = commits;
    i_scp_host_model.xfer({RW_WRITE, 7'h33, 8'hff}, 15, rd);
    i_scp_host_model.xfer({RW_WRITE, 7'h33, 8'hff}, 17, rd);
    cmp(16'(commits - n0), 16'h0000);
    rd_chk(7'h33, REG_RST);
    wr(7'h33, 8'h3c);
  endtask : t_refuse

  task automatic conclude;
    if (err_total == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude

  // reset for six cycles, then let the synchronisers settle
  initial begin
    repeat (6) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    repeat (6) @(posedge mclk_i);
    t_write();
    t_read3();
    t_read4();
    t_refuse();
    conclude();
  end
endmodule : scp_serial_port_tb
